// file: isr_status_top.sv
`default_nettype none

module isr_status_top #(
    parameter int NUM_CHAN = 4,
    parameter int CHAN_W = 2
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic CMD_VALID_I,
    input wire logic [4:0] CMD_CODE_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic CMD_CHAN_EXPLICIT_I,
    input wire logic [CHAN_W-1:0] CMD_CHAN_I,
    input wire logic OPC_CMD_I,
    input wire logic CMDS_DONE_I,
    input wire logic QUERY_NONE_I,
    input wire logic QUERY_UNREAD_I,
    input wire logic ERR_VALID_I,
    input wire logic [15:0] ERR_CODE_I,
    input wire logic LOCAL_MODE_I,
    input wire logic ERR_QUEUE_NONEMPTY_I,
    input wire logic MAV_I,
    input wire logic CAL_STATE_I,
    input wire logic [NUM_CHAN*16-1:0] CHAN_QUES_COND_I,
    output logic RSP_VALID_O,
    output logic [15:0] RSP_DATA_O,
    output logic [7:0] STATUS_BYTE_O,
    output logic IST_O,
    output logic SRQ_O
);
    // Elaboration check on channel count
    if (NUM_CHAN < 1 || NUM_CHAN > (1 << CHAN_W)) begin : g_chk
        $error("NUM_CHAN does not fit CHAN_W");
    end

    isr_pkg::isr_cmd_t cmd;
    logic cmd_fire;
    logic is_query;
    logic [7:0] standard_event_status;
    logic [7:0] esr_set;
    logic [7:0] event_status_enable_mask;
    logic [7:0] service_request_enable_mask;
    logic [7:0] parallel_poll_enable_mask;
    logic [7:0] stb_base;
    logic [7:0] stb;
    logic [7:0] stb_prev;
    logic [7:0] srq_rise;
    logic master_request_summary;
    logic individual_status_flag;
    logic opc_pending;
    logic local_q;
    logic [CHAN_W-1:0] sel_chan;
    logic [CHAN_W-1:0] chan_idx;
    logic signed [15:0] err_code;
    logic err_dev;
    logic err_exec;
    logic err_cmd;
    logic esr_clr;
    logic [15:0] oper_cond;
    logic [15:0] oper_cond_rd;
    logic [15:0] oper_event;
    logic oper_sum;
    logic [15:0] ques_cond_rd;
    logic [15:0] ques_event;
    logic ques_sum;
    logic [15:0] chan_word [NUM_CHAN];
    logic [15:0] ques_acc [NUM_CHAN+1];
    logic [15:0] next_rsp;

    // Command decode
    assign cmd = isr_pkg::isr_cmd_t'(CMD_CODE_I);
    assign cmd_fire = CMD_VALID_I;
    assign esr_clr = cmd_fire && (cmd == isr_pkg::CMD_ESR_Q || cmd == isr_pkg::CMD_CLS);

    // Error code classification
    assign err_code = $signed(ERR_CODE_I);
    assign err_dev = ERR_VALID_I && ((err_code >= isr_pkg::ERR_DEV_LO && err_code <= isr_pkg::ERR_DEV_HI)
        || err_code > $signed(isr_pkg::ZERO16));
    assign err_exec = ERR_VALID_I && err_code >= isr_pkg::ERR_EXEC_LO && err_code <= isr_pkg::ERR_EXEC_HI;
    assign err_cmd = ERR_VALID_I && err_code >= isr_pkg::ERR_CMD_LO && err_code <= isr_pkg::ERR_CMD_HI;

    // Event status set sources
    always_comb begin
        esr_set = isr_pkg::MASK8_RESET;
        // complete only after pending command finishes
        esr_set[isr_pkg::ESR_OPC] = opc_pending && CMDS_DONE_I;
        esr_set[isr_pkg::ESR_QUERY_ERR] = QUERY_NONE_I || QUERY_UNREAD_I;
        esr_set[isr_pkg::ESR_DEV_ERR] = err_dev;
        esr_set[isr_pkg::ESR_EXEC_ERR] = err_exec;
        esr_set[isr_pkg::ESR_CMD_ERR] = err_cmd;
        esr_set[isr_pkg::ESR_USER_REQ] = LOCAL_MODE_I && !local_q;
    end

    // Pending operation-complete tracker, a new command wins
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opc_pending <= 1'b0;
        end else begin
            opc_pending <= OPC_CMD_I || (opc_pending && !CMDS_DONE_I);
        end
    end

    // Local control edge history
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            local_q <= 1'b0;
        end else begin
            local_q <= LOCAL_MODE_I;
        end
    end

    // read clears, set wins over clear
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            standard_event_status <= isr_pkg::ESR_RESET;
        end else begin
            standard_event_status <= (esr_clr ? isr_pkg::MASK8_RESET : standard_event_status) | esr_set;
        end
    end

    // Enable masks and channel select, written by commands
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            event_status_enable_mask <= isr_pkg::MASK8_RESET;
            service_request_enable_mask <= isr_pkg::MASK8_RESET;
            parallel_poll_enable_mask <= isr_pkg::MASK8_RESET;
            sel_chan <= '0;
        end else if (cmd_fire) begin
            if (cmd == isr_pkg::CMD_ESE_W) begin
                event_status_enable_mask <= CMD_DATA_I[7:0];
            end
            if (cmd == isr_pkg::CMD_SRE_W) begin
                service_request_enable_mask <= CMD_DATA_I[7:0];
            end
            if (cmd == isr_pkg::CMD_PPE_W) begin
                parallel_poll_enable_mask <= CMD_DATA_I[7:0];
            end
            if (cmd == isr_pkg::CMD_CHAN_SEL_W) begin
                sel_chan <= CMD_DATA_I[CHAN_W-1:0];
            end
        end
    end

    // operation condition carries calibration state only
    always_comb begin
        oper_cond = isr_pkg::ZERO16;
        oper_cond[isr_pkg::OPER_CAL] = CAL_STATE_I;
    end

    // operation register with condition and event parts
    isr_scpi_reg #(
        .VALID_MASK(isr_pkg::OPER_VALID_MASK)
    ) u_oper (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .cond_i(oper_cond),
        .wdata_i(CMD_DATA_I),
        .en_wr_i(cmd_fire && cmd == isr_pkg::CMD_OPER_ENABLE_W),
        .ptr_wr_i(cmd_fire && cmd == isr_pkg::CMD_OPER_PTR_W),
        .ntr_wr_i(cmd_fire && cmd == isr_pkg::CMD_OPER_NTR_W),
        .event_rd_i(cmd_fire && cmd == isr_pkg::CMD_OPER_EVENT_Q),
        .clear_i(cmd_fire && cmd == isr_pkg::CMD_CLS),
        .cond_o(oper_cond_rd),
        .event_o(oper_event),
        .summary_o(oper_sum)
    );

    // questionable condition gathered from every channel
    assign ques_acc[0] = isr_pkg::ZERO16;
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        assign chan_word[i] = CHAN_QUES_COND_I[i*16 +: 16];
        assign ques_acc[i+1] = ques_acc[i] | chan_word[i];
    end

    // questionable keeps power, calibration and self-test bits
    isr_scpi_reg #(
        .VALID_MASK(isr_pkg::QUES_VALID_MASK)
    ) u_ques (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .cond_i(ques_acc[NUM_CHAN]),
        .wdata_i(CMD_DATA_I),
        .en_wr_i(cmd_fire && cmd == isr_pkg::CMD_QUES_ENABLE_W),
        .ptr_wr_i(cmd_fire && cmd == isr_pkg::CMD_QUES_PTR_W),
        .ntr_wr_i(cmd_fire && cmd == isr_pkg::CMD_QUES_NTR_W),
        .event_rd_i(cmd_fire && cmd == isr_pkg::CMD_QUES_EVENT_Q),
        .clear_i(cmd_fire && cmd == isr_pkg::CMD_CLS),
        .cond_o(ques_cond_rd),
        .event_o(ques_event),
        .summary_o(ques_sum)
    );

    // explicit channel overrides the selected one
    assign chan_idx = CMD_CHAN_EXPLICIT_I ? CMD_CHAN_I : sel_chan;

    // Status summary byte without its request bit
    always_comb begin
        stb_base = isr_pkg::MASK8_RESET;
        stb_base[isr_pkg::STB_ERRQ] = ERR_QUEUE_NONEMPTY_I;
        stb_base[isr_pkg::STB_QUES] = ques_sum;
        stb_base[isr_pkg::STB_MAV] = MAV_I;
        // event summary from enabled event bits
        stb_base[isr_pkg::STB_ESB] = |(standard_event_status & event_status_enable_mask);
        stb_base[isr_pkg::STB_OPER] = oper_sum;
    end

    // only bits 2,3,4,5,7 may request service
    assign master_request_summary = |(stb_base & service_request_enable_mask & isr_pkg::SRQ_SRC_MASK);

    always_comb begin
        stb = stb_base;
        stb[isr_pkg::STB_MSS] = master_request_summary;
    end

    // AND with parallel mask, then OR
    // bit six included here, unlike service requests
    assign individual_status_flag = |(stb & parallel_poll_enable_mask);

    // new enabled source raises a request
    assign srq_rise = stb_base & ~stb_prev & service_request_enable_mask & isr_pkg::SRQ_SRC_MASK;

    // Source history for request edges
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            stb_prev <= isr_pkg::MASK8_RESET;
        end else begin
            stb_prev <= stb_base;
        end
    end

    // request driven only from internal status
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SRQ_O <= 1'b0;
        end else if (|srq_rise) begin
            SRQ_O <= 1'b1;
        end else if (!master_request_summary || (cmd_fire && cmd == isr_pkg::CMD_SPOLL)) begin
            SRQ_O <= 1'b0;
        end
    end

    // summary byte presented for serial poll
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            STATUS_BYTE_O <= isr_pkg::MASK8_RESET;
            IST_O <= 1'b0;
        end else begin
            STATUS_BYTE_O <= stb;
            IST_O <= individual_status_flag;
        end
    end

    // Query response selection
    always_comb begin
        next_rsp = isr_pkg::ZERO16;
        is_query = 1'b1;
        unique case (cmd)
            isr_pkg::CMD_ESR_Q: next_rsp = {8'h00, standard_event_status};
            isr_pkg::CMD_ESE_Q: next_rsp = {8'h00, event_status_enable_mask};
            isr_pkg::CMD_SRE_Q: next_rsp = {8'h00, service_request_enable_mask};
            isr_pkg::CMD_PPE_Q: next_rsp = {8'h00, parallel_poll_enable_mask};
            isr_pkg::CMD_STB_Q, isr_pkg::CMD_SPOLL: next_rsp = {8'h00, stb};
            // query form of the individual flag
            isr_pkg::CMD_IST_Q: next_rsp = {15'h0000, individual_status_flag};
            isr_pkg::CMD_OPER_COND_Q: next_rsp = oper_cond_rd;
            isr_pkg::CMD_OPER_EVENT_Q: next_rsp = oper_event;
            isr_pkg::CMD_QUES_COND_Q: next_rsp = ques_cond_rd;
            isr_pkg::CMD_QUES_EVENT_Q: next_rsp = ques_event;
            isr_pkg::CMD_CHAN_COND_Q: begin
                if (32'(chan_idx) < NUM_CHAN) begin
                    next_rsp = chan_word[chan_idx];
                end
            end
            default: is_query = 1'b0;
        endcase
    end

    // Response register, one cycle after the command
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_DATA_O <= isr_pkg::ZERO16;
        end else begin
            RSP_VALID_O <= cmd_fire && is_query;
            if (cmd_fire && is_query) begin
                RSP_DATA_O <= next_rsp;
            end
        end
    end

    a_ist_bit6: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (parallel_poll_enable_mask[isr_pkg::STB_MSS] && master_request_summary) |=> IST_O)
        else $error("bit six not honoured by parallel mask");
    a_ist_masked: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (parallel_poll_enable_mask == isr_pkg::MASK8_RESET) |=> !IST_O)
        else $error("individual flag set with empty mask");
    a_esb_raise: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        ((|(esr_set & event_status_enable_mask)) && !(cmd_fire && (cmd == isr_pkg::CMD_ESE_W || cmd == isr_pkg::CMD_CLS)))
        |=> ##1 STATUS_BYTE_O[isr_pkg::STB_ESB])
        else $error("event summary bit not raised");
    a_opc_cause: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (!standard_event_status[isr_pkg::ESR_OPC] ##1 standard_event_status[isr_pkg::ESR_OPC]) |-> $past(opc_pending && CMDS_DONE_I))
        else $error("operation complete without pending command");
    a_query_err: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (QUERY_NONE_I || QUERY_UNREAD_I) |=> standard_event_status[isr_pkg::ESR_QUERY_ERR])
        else $error("query error not latched");
    a_dev_err: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (ERR_VALID_I && err_code == isr_pkg::ERR_DEV_HI) |=> standard_event_status[isr_pkg::ESR_DEV_ERR])
        else $error("device error not latched");
    a_exec_err: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (ERR_VALID_I && err_code == isr_pkg::ERR_EXEC_HI) |=> standard_event_status[isr_pkg::ESR_EXEC_ERR])
        else $error("execution error not latched");
    a_cmd_err: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (ERR_VALID_I && err_code == isr_pkg::ERR_CMD_LO) |=> standard_event_status[isr_pkg::ESR_CMD_ERR])
        else $error("command error not latched");
    a_bit1_unused: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        !standard_event_status[1])
        else $error("unused event bit set");
    a_srq_cause: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        $rose(SRQ_O) |-> $past(|srq_rise))
        else $error("service request without enabled rise");
    a_srq_raise: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (|srq_rise) |=> SRQ_O)
        else $error("service request not raised");
    a_esr_clear: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (cmd_fire && cmd == isr_pkg::CMD_ESR_Q && esr_set == isr_pkg::MASK8_RESET)
        |=> (standard_event_status == isr_pkg::MASK8_RESET) && RSP_VALID_O && RSP_DATA_O[7:0] == $past(standard_event_status))
        else $error("event status read did not return and clear");
endmodule

`default_nettype wire

// file: isr_pkg.sv
// Operation
// - Individual flag is OR of summary AND parallel mask
// - Parallel mask honours summary bit six
// - Individual flag by poll and query
// - Enabled event bit sets event summary bit
// - Operation complete after command and idle
// - Query error on unmatched read or write
// - Device error for minus three hundreds, positive
// - Execution error for minus two hundreds
// - Command error for minus one hundreds
// - User request on local; bit one unused
// - Power on bit set at power up
// - Operation register: calibration bit one only
// - Operation condition and event both queryable
// - Questionable: power, calibration, self-test bits
// - Channel sub-registers; selected channel by default
// - Service request only from bits 2,3,4,5,7
// - Only the instrument initiates service requests
// - Serial poll returns the summary byte
// - Service request on enabled summary rise
// - Event reads clear; others unchanged by read
// - Event latches per rising/falling filters
// - Summary bit six is master request summary
`default_nettype none

package isr_pkg;
    localparam int STAT_W = 16;
    localparam int SB_W = 8;
    localparam int CMD_W = 5;

    // Event status bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QUERY_ERR = 2;
    localparam int ESR_DEV_ERR = 3;
    localparam int ESR_EXEC_ERR = 4;
    localparam int ESR_CMD_ERR = 5;
    localparam int ESR_USER_REQ = 6;
    localparam int ESR_POWER_ON = 7;

    // Status summary byte positions
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OPER = 7;
    localparam logic [7:0] SRQ_SRC_MASK = 8'hbc;

    // Operation and questionable bit positions and implemented bits
    localparam int OPER_CAL = 1;
    localparam int QUES_POWER = 3;
    localparam int QUES_CAL = 8;
    localparam int QUES_SELFTEST = 9;
    localparam logic [15:0] OPER_VALID_MASK = 16'h0002;
    localparam logic [15:0] QUES_VALID_MASK = 16'h0308;

    // Reset values
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] MASK8_RESET = 8'h00;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] PTR_RESET = 16'hffff;
    localparam logic [15:0] NTR_RESET = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // Error code ranges, inclusive
    localparam logic signed [15:0] ERR_DEV_LO = -16'sh018f;
    localparam logic signed [15:0] ERR_DEV_HI = -16'sh012c;
    localparam logic signed [15:0] ERR_EXEC_LO = -16'sh012b;
    localparam logic signed [15:0] ERR_EXEC_HI = -16'sh00c8;
    localparam logic signed [15:0] ERR_CMD_LO = -16'sh00c7;
    localparam logic signed [15:0] ERR_CMD_HI = -16'sh0064;

    // Command codes from the remote command parser
    typedef enum logic [4:0] {
        CMD_NONE = 5'h00,
        CMD_ESR_Q = 5'h01,
        CMD_ESE_W = 5'h02,
        CMD_ESE_Q = 5'h03,
        CMD_SRE_W = 5'h04,
        CMD_SRE_Q = 5'h05,
        CMD_PPE_W = 5'h06,
        CMD_PPE_Q = 5'h07,
        CMD_STB_Q = 5'h08,
        CMD_IST_Q = 5'h09,
        CMD_CLS = 5'h0a,
        CMD_OPER_COND_Q = 5'h0b,
        CMD_OPER_EVENT_Q = 5'h0c,
        CMD_OPER_ENABLE_W = 5'h0d,
        CMD_OPER_PTR_W = 5'h0e,
        CMD_OPER_NTR_W = 5'h0f,
        CMD_QUES_COND_Q = 5'h10,
        CMD_QUES_EVENT_Q = 5'h11,
        CMD_QUES_ENABLE_W = 5'h12,
        CMD_QUES_PTR_W = 5'h13,
        CMD_QUES_NTR_W = 5'h14,
        CMD_CHAN_SEL_W = 5'h15,
        CMD_CHAN_COND_Q = 5'h16,
        CMD_SPOLL = 5'h17
    } isr_cmd_t;
endpackage

`default_nettype wire

// file: isr_scpi_reg.sv
`default_nettype none

module isr_scpi_reg #(
    parameter logic [15:0] VALID_MASK = 16'hffff
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] cond_i,
    input wire logic [15:0] wdata_i,
    input wire logic en_wr_i,
    input wire logic ptr_wr_i,
    input wire logic ntr_wr_i,
    input wire logic event_rd_i,
    input wire logic clear_i,
    output logic [15:0] cond_o,
    output logic [15:0] event_o,
    output logic summary_o
);
    logic [15:0] cond_q;
    logic [15:0] enable;
    logic [15:0] ptr;
    logic [15:0] falling_transition_filter;
    logic [15:0] event_bits;
    logic [15:0] rise;
    logic [15:0] fall;

    // Unimplemented bits, bit 15 among them, always read zero
    assign cond_o = cond_i & VALID_MASK;
    assign event_o = event_bits;
    assign summary_o = |(event_bits & enable);

    assign rise = cond_o & ~cond_q & ptr;
    assign fall = ~cond_o & cond_q & falling_transition_filter;

    // Previous condition for edge detection
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cond_q <= isr_pkg::ZERO16;
        end else begin
            cond_q <= cond_o;
        end
    end

    // Writable filter and enable parts; reads do not touch them
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable <= isr_pkg::ENABLE_RESET;
            ptr <= isr_pkg::PTR_RESET;
            falling_transition_filter <= isr_pkg::NTR_RESET;
        end else begin
            if (en_wr_i) begin
                enable <= wdata_i & VALID_MASK;
            end
            if (ptr_wr_i) begin
                ptr <= wdata_i & VALID_MASK;
            end
            if (ntr_wr_i) begin
                falling_transition_filter <= wdata_i & VALID_MASK;
            end
        end
    end

    // event cleared by read, new edge wins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            event_bits <= isr_pkg::ZERO16;
        end else begin
            event_bits <= ((event_rd_i || clear_i) ? isr_pkg::ZERO16 : event_bits) | rise | fall;
        end
    end

    a_event_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ((rise | fall) != isr_pkg::ZERO16) |=> ((event_bits & $past(rise | fall)) == $past(rise | fall)))
        else $error("filtered edge did not latch");
    a_event_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (event_rd_i && (rise | fall) == isr_pkg::ZERO16) |=> event_bits == isr_pkg::ZERO16)
        else $error("event set without filtered edge");
endmodule

`default_nettype wire

// file: isr_ctrl_model.sv
`default_nettype none

// Remote controller: issues command codes, never drives the request line
module isr_ctrl_model (
    input wire logic clk_i,
    input wire logic srq_i,
    output logic cmd_valid_o,
    output logic [4:0] cmd_code_o,
    output logic [15:0] cmd_data_o,
    output logic chan_expl_o,
    output logic [1:0] chan_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int srq_seen = 0;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 5'h00;
        cmd_data_o = 16'h0000;
        chan_expl_o = 1'b0;
        chan_o = 2'h0;
    end

    always @(posedge srq_i) begin
        srq_seen++;
    end

    // One command per call; fields inverted once released
    task automatic issue(input isr_pkg::isr_cmd_t code, input logic [15:0] data, input logic expl,
                         input logic [1:0] chan);
        cmd_valid_o = 1'b1;
        cmd_code_o = code;
        cmd_data_o = data;
        chan_expl_o = expl;
        chan_o = chan;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_code_o = ~cmd_code_o;
        cmd_data_o = ~cmd_data_o;
        chan_expl_o = ~chan_expl_o;
        chan_o = ~chan_o;
    endtask
endmodule

`default_nettype wire

// file: tb_top.sv
`default_nettype none
`define CHK(g, e) check(16'(g), 16'(e))

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, opc = 1'b0, done = 1'b0, qnone = 1'b0, qunread = 1'b0;
    logic err_v = 1'b0, local_mode = 1'b0, cal = 1'b0, errq = 1'b0, mav = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic [63:0] chan_cond = 64'h0000_1234_ffff_0008;
    logic cmd_valid, cmd_expl, rsp_valid, individual_status_flag, srq;
    logic [4:0] cmd_code;
    logic [15:0] cmd_data, rsp_data;
    logic [1:0] cmd_chan;
    logic [7:0] status_byte;
    int fails = 0, compares = 0, cycles = 0;
    logic [15:0] codes [7] = '{16'hfed4, 16'hfe71, 16'h0005, 16'hff38, 16'hfed5, 16'hff9c, 16'hff39};
    int bits [7] = '{3, 3, 3, 4, 4, 5, 5};

    isr_status_top DUT (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_valid), .CMD_CODE_I(cmd_code),
        .CMD_DATA_I(cmd_data), .CMD_CHAN_EXPLICIT_I(cmd_expl), .CMD_CHAN_I(cmd_chan), .OPC_CMD_I(opc),
        .CMDS_DONE_I(done), .QUERY_NONE_I(qnone), .QUERY_UNREAD_I(qunread), .ERR_VALID_I(err_v),
        .ERR_CODE_I(err_code), .LOCAL_MODE_I(local_mode), .ERR_QUEUE_NONEMPTY_I(errq), .MAV_I(mav),
        .CAL_STATE_I(cal), .CHAN_QUES_COND_I(chan_cond), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
        .STATUS_BYTE_O(status_byte), .IST_O(individual_status_flag), .SRQ_O(srq));
    isr_ctrl_model ctrl (.clk_i(clk), .srq_i(srq), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
        .cmd_data_o(cmd_data), .chan_expl_o(cmd_expl), .chan_o(cmd_chan));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    task automatic wr(input isr_pkg::isr_cmd_t c, input logic [15:0] d);
        ctrl.issue(c, d, 1'b0, 2'h0);
        tick(1);
    endtask

    // Query and compare the one-cycle answer
    task automatic q(input isr_pkg::isr_cmd_t c, input logic [15:0] e, input logic x = 1'b0,
                     input logic [1:0] ch = 2'h0);
        ctrl.issue(c, 16'h0000, x, ch);
        `CHK(rsp_valid, 1'b1);
        `CHK(rsp_data, e);
        tick(1);
    endtask

    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        tick(4);
        arst_n = 1'b1;
        // power-on flag then cleared by read
        q(isr_pkg::CMD_ESR_Q, 16'h0080);
        q(isr_pkg::CMD_ESR_Q, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            err_code = codes[i];
            pulse(err_v);
            q(isr_pkg::CMD_ESR_Q, 16'h0001 << bits[i]);
        end
        pulse(qnone);
        q(isr_pkg::CMD_ESR_Q, 16'h0004);
        pulse(qunread);
        q(isr_pkg::CMD_ESR_Q, 16'h0004);
        local_mode = 1'b1;
        tick(1);
        q(isr_pkg::CMD_ESR_Q, 16'h0040);
        local_mode = 1'b0;
        pulse(opc);
        tick(3);
        q(isr_pkg::CMD_ESR_Q, 16'h0000);
        done = 1'b1;
        tick(3);
        q(isr_pkg::CMD_ESR_Q, 16'h0001);
        $display("test events done");
        wr(isr_pkg::CMD_ESE_W, 16'h00ff);
        wr(isr_pkg::CMD_SRE_W, 16'h00ff);
        wr(isr_pkg::CMD_PPE_W, 16'h0040);
        err_code = 16'hfed4;
        pulse(err_v);
        tick(1);
        `CHK(status_byte, 8'h60);
        `CHK(srq, 1'b1);
        `CHK(individual_status_flag, 1'b1);
        q(isr_pkg::CMD_IST_Q, 16'h0001);
        q(isr_pkg::CMD_STB_Q, 16'h0060);
        wr(isr_pkg::CMD_SPOLL, 16'h0000);
        tick(1);
        `CHK(srq, 1'b0);
        q(isr_pkg::CMD_ESR_Q, 16'h0008);
        tick(2);
        `CHK(status_byte, 8'h00);
        // bit six of the request mask is ignored
        wr(isr_pkg::CMD_SRE_W, 16'h0040);
        pulse(err_v);
        tick(3);
        `CHK(status_byte, 8'h20);
        `CHK(srq, 1'b0);
        errq = 1'b1;
        mav = 1'b1;
        tick(2);
        `CHK(status_byte, 8'h34);
        errq = 1'b0;
        mav = 1'b0;
        wr(isr_pkg::CMD_PPE_W, 16'h0020);
        tick(1);
        `CHK(individual_status_flag, 1'b1);
        wr(isr_pkg::CMD_PPE_W, 16'h0000);
        tick(1);
        `CHK(individual_status_flag, 1'b0);
        q(isr_pkg::CMD_ESR_Q, 16'h0008);
        $display("test summary done");
        cal = 1'b1;
        tick(2);
        q(isr_pkg::CMD_OPER_COND_Q, 16'h0002);
        q(isr_pkg::CMD_OPER_EVENT_Q, 16'h0002);
        q(isr_pkg::CMD_OPER_EVENT_Q, 16'h0000);
        wr(isr_pkg::CMD_OPER_PTR_W, 16'h0000);
        wr(isr_pkg::CMD_OPER_NTR_W, 16'h0002);
        wr(isr_pkg::CMD_OPER_ENABLE_W, 16'h0002);
        cal = 1'b0;
        tick(4);
        `CHK(status_byte & 8'h80, 8'h80);
        q(isr_pkg::CMD_OPER_EVENT_Q, 16'h0002);
        q(isr_pkg::CMD_OPER_COND_Q, 16'h0000);
        q(isr_pkg::CMD_QUES_COND_Q, 16'h0308);
        wr(isr_pkg::CMD_CHAN_SEL_W, 16'h0001);
        q(isr_pkg::CMD_CHAN_COND_Q, 16'hffff);
        q(isr_pkg::CMD_CHAN_COND_Q, 16'h1234, 1'b1, 2'h2);
        $display("test registers done");
        print_verdict();
    end
endmodule

`default_nettype wire
